// >>> res_regs.svh
`ifndef RES_REGS_SVH
`define RES_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define RES_ADDR_VSET_LO   8'h00
`define RES_ADDR_VSET_HI   8'h01
`define RES_ADDR_CTRL      8'h02
`define RES_ADDR_MON       8'h05
// ****************************************
// field positions and reset values
// ****************************************
`define RES_RUN_BIT        7
`define RES_BLEED_BIT      7
`define RES_MODE_LO_BIT    0
`define RES_MODE_HI_BIT    1
`define RES_MON_ON_BIT     7
`define RES_MON_COOL_BIT   6
`define RES_MON_RAMP_BIT   1
`define RES_MON_RUN_BIT    0
`define RES_VSET_RST       8'hC0
`define RES_CTRL_RST       8'h82
// ****************************************
// timing
// ****************************************
`define RES_ILIM_TRIP_CNT  5'h10
`define RES_OFF_TIME_US    1700
`define RES_CLK_KHZ        10000
`define RES_OFF_CYC        ((`RES_OFF_TIME_US * `RES_CLK_KHZ) / 1000)
`define RES_RAMP_STEP_CYC  4'h4
`endif

// >>> res_pkg.sv
package res_pkg;
	// one-hot sequencer states
	typedef enum logic [3:0] {
		RES_OFF  = 4'b0001,
		RES_RAMP = 4'b0010,
		RES_RUN  = 4'b0100,
		RES_COOL = 4'b1000
	} res_state_t;
	typedef logic [6:0] res_code_t;
endpackage

// >>> res_seq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface res_seq_if;
	import res_pkg::*;
	logic      ramping;
	logic      running;
	logic      cooling;
	logic      switching;
	res_code_t target;
	res_code_t ref_code;
	logic      ramp_done;
	logic      ilim_trip;
	logic      cool_done;
	modport ctl   (output ramping, running, cooling, switching, target,
	               input ref_code, ramp_done, ilim_trip, cool_done);
	modport ramp  (input ramping, running, target, output ref_code, ramp_done);
	modport guard (input switching, cooling, output ilim_trip, cool_done);
endinterface
`default_nettype wire

// >>> res_soft_start.sv
`timescale 1ns/1ps
`default_nettype none
`include "res_regs.svh"
module res_soft_start
	import res_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic resetn,
	res_seq_if.ramp   seq
);
	logic [3:0] step_ff;
	res_code_t  ref_ff;

	// step pacing: one code step per pacing period keeps surge current low
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			step_ff <= 4'h0;
		end else if (!seq.ramping || step_ff == `RES_RAMP_STEP_CYC - 4'h1) begin
			step_ff <= 4'h0;
		end else begin
			step_ff <= step_ff + 4'h1;
		end
	end

	// reference climbs from zero while ramping, tracks target while running
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ref_ff <= 7'h00;
		end else if (seq.running) begin
			ref_ff <= seq.target;
		end else if (!seq.ramping) begin
			ref_ff <= 7'h00;
		end else if (step_ff == `RES_RAMP_STEP_CYC - 4'h1) begin
			if (ref_ff < seq.target) begin
				ref_ff <= ref_ff + 7'h01;
			end else if (ref_ff > seq.target) begin
				ref_ff <= ref_ff - 7'h01;
			end
		end
	end

	assign seq.ref_code  = ref_ff;
	assign seq.ramp_done = seq.ramping && (ref_ff == seq.target);

	// a lowered target may legally walk the reference down, so only a
	// ramp that was still below a steady target must never fall
	a_ramp_monotone: assert property (@(posedge ref_clk) disable iff (!resetn)
		seq.ramping && $past(seq.ramping) && $stable(seq.target)
		&& $past(seq.target) >= $past(ref_ff)
		|-> ref_ff >= $past(ref_ff))
		else $error("reference fell during soft-start");
endmodule
`default_nettype wire

// >>> res_ilim_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "res_regs.svh"
module res_ilim_guard
	import res_pkg::*;
#(
	parameter int OFF_CYC = `RES_OFF_CYC
)(
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic ilim_hit,
	input  wire logic cycle_end,
	res_seq_if.guard  seq
);
	logic [4:0]  hit_cnt_ff;
	logic [14:0] off_tmr_ff;

	// consecutive limit cycles; any clean cycle starts the count over
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			hit_cnt_ff <= 5'h00;
		end else if (!seq.switching) begin
			hit_cnt_ff <= 5'h00;
		end else if (cycle_end) begin
			hit_cnt_ff <= ilim_hit ? hit_cnt_ff + 5'h01 : 5'h00;
		end
	end

	assign seq.ilim_trip = seq.switching && cycle_end && ilim_hit
	                       && (hit_cnt_ff == `RES_ILIM_TRIP_CNT - 5'h01);

	// off timer on the internal clock, loaded at the trip
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			off_tmr_ff <= 15'h0000;
		end else if (seq.ilim_trip) begin
			off_tmr_ff <= 15'(OFF_CYC - 1);
		end else if (off_tmr_ff != 15'h0000) begin
			off_tmr_ff <= off_tmr_ff - 15'h0001;
		end
	end

	assign seq.cool_done = seq.cooling && (off_tmr_ff == 15'h0000);

	a_clean_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
		seq.switching && cycle_end && !ilim_hit |=> hit_cnt_ff == 5'h00)
		else $error("limit count not cleared by clean cycle");
endmodule
`default_nettype wire

// >>> res_top.sv
// What this block does
// - enable pin low forces shutdown, output off
// - registers stay accessible with pin low
// - pin low never alters register contents
// - power-on reset loads all register defaults
// - bleed bit plus off request connects discharge
// - enable rise with run bit starts soft-start
// - soft-start ramps reference, rectifier held off
// - sixteen limit cycles tri-state, wait 1700us
// - both run bits reset to one
// - select pin picks which run bit gates
// - mode bits with select pick pulse/PWM
// - select pin picks voltage setting register
`timescale 1ns/1ps
`default_nettype none
`include "res_regs.svh"
module res_top
	import res_pkg::*;
#(
	parameter int OFF_CYC = `RES_OFF_CYC
)(
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       supply_ok,
	input  wire logic       hw_enable_pin,
	input  wire logic       voltage_select_pin,
	input  wire logic       ilim_hit,
	input  wire logic       cycle_end,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            regulator_on,
	output logic            switch_tristate,
	output logic            discharge_on,
	output logic            sync_rect_en,
	output logic            forced_fixed_freq_mode,
	output logic            light_load_pulse_mode,
	output logic      [6:0] ref_level,
	output logic      [6:0] vout_code
);
	// ****************************************
	// declarations
	// ****************************************
	res_seq_if  seq ();
	res_state_t state_ff;
	res_state_t nxt_state;
	logic [7:0] vset_lo_ff;
	logic [7:0] vset_hi_ff;
	logic [7:0] ctrl_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic       run_req_q_ff;
	logic       run_bit;
	logic       run_req;
	logic       run_rise;
	logic       forced;
	res_code_t  target;
	logic [14:0] cool_len_ff;

	// ****************************************
	// register file
	// ****************************************

	// only the bus writes these; the enable pin is deliberately absent
	// so shutdown keeps whatever software programmed
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			vset_lo_ff <= `RES_VSET_RST;
			vset_hi_ff <= `RES_VSET_RST;
			ctrl_ff    <= `RES_CTRL_RST;
		end else if (reg_wr && supply_ok) begin
			unique case (reg_addr)
				`RES_ADDR_VSET_LO: begin
					vset_lo_ff <= reg_wdata;
				end
				`RES_ADDR_VSET_HI: begin
					vset_hi_ff <= reg_wdata;
				end
				`RES_ADDR_CTRL: begin
					ctrl_ff <= reg_wdata;
				end
				default: begin
					// unmapped or read-only: ignored
				end
			endcase
		end
	end

	// read mux; unmapped offsets and a starved supply read as zero
	always_comb begin
		nxt_rdata = 8'h00;
		if (reg_rd && supply_ok) begin
			unique case (reg_addr)
				`RES_ADDR_VSET_LO: begin
					nxt_rdata = vset_lo_ff;
				end
				`RES_ADDR_VSET_HI: begin
					nxt_rdata = vset_hi_ff;
				end
				`RES_ADDR_CTRL: begin
					nxt_rdata = ctrl_ff;
				end
				`RES_ADDR_MON: begin
					nxt_rdata = 8'h00;
					nxt_rdata[`RES_MON_ON_BIT]   = regulator_on;
					nxt_rdata[`RES_MON_COOL_BIT] = seq.cooling;
					nxt_rdata[`RES_MON_RAMP_BIT] = seq.ramping;
					nxt_rdata[`RES_MON_RUN_BIT]  = seq.running;
				end
				default: begin
					nxt_rdata = 8'h00;
				end
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

	// ****************************************
	// enable decode
	// ****************************************

	// select pin chooses which software run bit and which setting apply
	assign run_bit = voltage_select_pin ? vset_hi_ff[`RES_RUN_BIT]
	                                    : vset_lo_ff[`RES_RUN_BIT];
	assign run_req = hw_enable_pin && run_bit;
	assign target  = voltage_select_pin ? vset_hi_ff[6:0] : vset_lo_ff[6:0];
	assign forced  = voltage_select_pin ? ctrl_ff[`RES_MODE_HI_BIT]
	                                    : ctrl_ff[`RES_MODE_LO_BIT];

	// previous request level for start edge detection; resets low so a
	// request already present at release counts as a fresh start
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			run_req_q_ff <= 1'b0;
		end else begin
			run_req_q_ff <= run_req;
		end
	end

	assign run_rise = run_req && !run_req_q_ff;

	// ****************************************
	// sequencer
	// ****************************************

	// losing the request always wins; a trip beats ramp completion
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			RES_OFF: begin
				if (run_rise) begin
					nxt_state = RES_RAMP;
				end
			end
			RES_RAMP: begin
				if (!run_req) begin
					nxt_state = RES_OFF;
				end else if (seq.ilim_trip) begin
					nxt_state = RES_COOL;
				end else if (seq.ramp_done) begin
					nxt_state = RES_RUN;
				end
			end
			RES_RUN: begin
				if (!run_req) begin
					nxt_state = RES_OFF;
				end else if (seq.ilim_trip) begin
					nxt_state = RES_COOL;
				end
			end
			RES_COOL: begin
				if (!run_req) begin
					nxt_state = RES_OFF;
				end else if (seq.cool_done) begin
					nxt_state = RES_RAMP;
				end
			end
			default: begin
				nxt_state = RES_OFF;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= RES_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************
	// submodules
	// ****************************************
	assign seq.ramping   = (state_ff == RES_RAMP);
	assign seq.running   = (state_ff == RES_RUN);
	assign seq.cooling   = (state_ff == RES_COOL);
	assign seq.switching = seq.ramping || seq.running;
	assign seq.target    = target;

	res_soft_start u_ramp (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.seq     (seq.ramp)
	);

	res_ilim_guard #(
		.OFF_CYC (OFF_CYC)
	) u_guard (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.ilim_hit  (ilim_hit),
		.cycle_end (cycle_end),
		.seq       (seq.guard)
	);

	// ****************************************
	// outputs
	// ****************************************

	// switch and rectifier controls follow the state flops directly; discharge decodes the bleed bit, enable pin and selected run bit
	assign regulator_on    = seq.switching;
	assign switch_tristate = !seq.switching;
	assign sync_rect_en    = seq.running;
	assign discharge_on    = ctrl_ff[`RES_BLEED_BIT]
	                         && (!hw_enable_pin || !run_bit);
	assign forced_fixed_freq_mode = forced;
	assign light_load_pulse_mode  = !forced;
	assign ref_level = seq.ref_code;
	assign vout_code = target;

	// ****************************************
	// checks
	// ****************************************

	// cycles spent in the off-time state, read only by a check
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cool_len_ff <= 15'h0000;
		end else if (state_ff != RES_COOL) begin
			cool_len_ff <= 15'h0000;
		end else begin
			cool_len_ff <= cool_len_ff + 15'h0001;
		end
	end

	sequence s_trip_taken;
		seq.switching && run_req && seq.ilim_trip;
	endsequence

	sequence s_cool_entered;
		(state_ff == RES_COOL) && switch_tristate && !regulator_on;
	endsequence

	property p_trip_to_cool;
		@(posedge ref_clk) disable iff (!resetn)
		s_trip_taken |=> s_cool_entered;
	endproperty

	a_pin_low_off: assert property (@(posedge ref_clk) disable iff (!resetn)
		!hw_enable_pin |=> !regulator_on && !sync_rect_en)
		else $error("regulator on while enable pin low");

	a_reg_read_back: assert property (@(posedge ref_clk) disable iff (!resetn)
		reg_rd && supply_ok && reg_addr == `RES_ADDR_CTRL
		|=> reg_rdata == $past(ctrl_ff))
		else $error("control register read back wrong");

	a_regs_kept_low: assert property (@(posedge ref_clk) disable iff (!resetn)
		$fell(hw_enable_pin) && !$past(reg_wr)
		|-> $stable(vset_lo_ff) && $stable(vset_hi_ff) && $stable(ctrl_ff))
		else $error("registers changed when enable pin fell");

	// decoded again from the pins and stored bits, not from run_bit
	a_bleed_on_off: assert property (@(posedge ref_clk) disable iff (!resetn)
		discharge_on == (ctrl_ff[`RES_BLEED_BIT] && (!hw_enable_pin
		|| (voltage_select_pin ? !vset_hi_ff[`RES_RUN_BIT] : !vset_lo_ff[`RES_RUN_BIT]))))
		else $error("discharge load wrong for bleed bit and enables");

	// a zero target may finish the ramp at once, so only the entry cycle
	// is pinned down here
	a_start_ramp: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state_ff == RES_OFF) && run_req && !run_req_q_ff
		|=> (state_ff == RES_RAMP) && !sync_rect_en && (seq.ref_code == 7'h00))
		else $error("enable rise did not start soft-start");

	a_ramp_no_rect: assert property (@(posedge ref_clk) disable iff (!resetn)
		seq.ramping && $past(seq.ramping)
		|-> !sync_rect_en && (seq.ref_code == $past(seq.ref_code)
		|| seq.ref_code == $past(seq.ref_code) + 7'h01
		|| seq.ref_code == $past(seq.ref_code) - 7'h01))
		else $error("rectifier on or reference jumped during soft-start");

	a_trip_tristate: assert property (p_trip_to_cool)
		else $error("limit trip did not tri-state switch");

	a_off_time: assert property (@(posedge ref_clk) disable iff (!resetn)
		$past(state_ff == RES_COOL) && (state_ff == RES_RAMP)
		|-> cool_len_ff == 15'(OFF_CYC))
		else $error("restart off time wrong length");

	a_sel_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
		hw_enable_pin && !voltage_select_pin && !vset_lo_ff[`RES_RUN_BIT]
		|=> !regulator_on)
		else $error("low-select run bit did not gate output");

	a_mode_pick: assert property (@(posedge ref_clk) disable iff (!resetn)
		voltage_select_pin && ctrl_ff[`RES_MODE_HI_BIT]
		|-> forced_fixed_freq_mode && !light_load_pulse_mode)
		else $error("forced mode not applied for high select");

	a_vout_pick: assert property (@(posedge ref_clk) disable iff (!resetn)
		!voltage_select_pin |-> vout_code == vset_lo_ff[6:0])
		else $error("low select did not use first setting");
endmodule
`default_nettype wire

// >>> res_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host side: register port master and pins
// ****************************************
module res_host_model
	import res_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic            hw_enable_pin,
	output logic            voltage_select_pin,
	output logic            supply_ok
);
	// idle bus at time zero, pins low, supply good
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		hw_enable_pin = 1'b0;
		voltage_select_pin = 1'b0;
		supply_ok = 1'b1;
	end
	// one-cycle write strobe; data flipped after so a late sample shows
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// pins change just after an edge
	task automatic pins(input logic en, input logic sel, input logic sup);
		@(posedge ref_clk);
		hw_enable_pin <= en;
		voltage_select_pin <= sel;
		supply_ok <= sup;
	endtask
endmodule
`default_nettype wire

// >>> test_regulator_enable_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "res_regs.svh"
module test_regulator_enable_sequencer
	import res_pkg::*;
;
	localparam int OFF_C = 20;
	logic       ref_clk, resetn, ilim_hit, cycle_end, reg_wr, reg_rd;
	logic       hw_enable_pin, voltage_select_pin, supply_ok;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic       regulator_on, switch_tristate, discharge_on, sync_rect_en;
	logic       forced_fixed_freq_mode, light_load_pulse_mode;
	logic [6:0] ref_level, vout_code;
	logic [7:0] exp_reg [0:2];
	int         mismatches = 0;
	int         n_checks = 0;
	int         seed = 98;
	// ****************************************
	// design and host
	// ****************************************
	res_top #(.OFF_CYC(OFF_C)) res_top_i (.ref_clk(ref_clk), .resetn(resetn),
		.supply_ok(supply_ok), .hw_enable_pin(hw_enable_pin),
		.voltage_select_pin(voltage_select_pin), .ilim_hit(ilim_hit),
		.cycle_end(cycle_end), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.regulator_on(regulator_on), .switch_tristate(switch_tristate),
		.discharge_on(discharge_on), .sync_rect_en(sync_rect_en),
		.forced_fixed_freq_mode(forced_fixed_freq_mode),
		.light_load_pulse_mode(light_load_pulse_mode),
		.ref_level(ref_level), .vout_code(vout_code));
	res_host_model res_host_model_i (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .hw_enable_pin(hw_enable_pin),
		.voltage_select_pin(voltage_select_pin), .supply_ok(supply_ok));
	// ****************************************
	// compare tasks and reference model
	// ****************************************
	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_code(input string nm, input logic [6:0] e, input logic [6:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %b seen %b", nm, e, g);
		end
	endtask
	// model is updated only when the write can land
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		res_host_model_i.wr(a, d);
		if (supply_ok && a < 8'h03) exp_reg[a[1:0]] = d;
	endtask
	// unmapped places and a dead supply read as zero
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] mon);
		logic [7:0] d;
		res_host_model_i.rd(a, d);
		chk_reg("register read", !supply_ok ? 8'h00 : (a < 8'h03) ? exp_reg[a[1:0]] :
			(a == `RES_ADDR_MON) ? mon : 8'h00, d);
	endtask
	// outputs that follow pins and registers directly
	task automatic chk_static();
		logic [7:0] v;
		v = exp_reg[voltage_select_pin];
		chk_bit("discharge", exp_reg[2][7] & (~hw_enable_pin | ~v[7]), discharge_on);
		chk_bit("forced", exp_reg[2][voltage_select_pin], forced_fixed_freq_mode);
		chk_bit("pulse", ~exp_reg[2][voltage_select_pin], light_load_pulse_mode);
		chk_code("vout", v[6:0], vout_code);
	endtask
	// bounded wait on regulator_on (0) or sync_rect_en (1)
	task automatic wait_for(input int which, input int lim, output int n);
		n = 0;
		do begin
			@(posedge ref_clk);
			#1 n++;
		end while (((which == 0) ? regulator_on : sync_rect_en) !== 1'b1 && n < lim);
	endtask
	task automatic pulse(input logic hit);
		@(posedge ref_clk);
		cycle_end <= 1'b1;
		ilim_hit <= hit;
		@(posedge ref_clk);
		cycle_end <= 1'b0;
		ilim_hit <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ****************************************
	// clock, watchdog, sequence
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// the run needs a few hundred cycles; twenty thousand means a hang
	initial begin
		#(100 * 20000);
		mismatches++;
		report_and_stop();
	end
	initial begin
		int         n;
		logic [7:0] code;
		logic [7:0] r;
		resetn = 1'b0;
		cycle_end = 1'b0;
		ilim_hit = 1'b0;
		exp_reg[0] = `RES_VSET_RST;
		exp_reg[1] = `RES_VSET_RST;
		exp_reg[2] = `RES_CTRL_RST;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		// defaults, holes and idle monitor
		for (int a = 0; a < 8; a++) rd_chk(a[7:0], 8'h00);
		chk_bit("on", 1'b0, regulator_on);
		chk_bit("tristate", 1'b1, switch_tristate);
		chk_static();
		$display("test reset done");
		// registers and modes with the enable pin low
		code = (8'($random(seed)) & 8'h0F) + 8'h02;
		wr(`RES_ADDR_VSET_LO, {1'b1, code[6:0]});
		wr(`RES_ADDR_VSET_HI, {1'b1, 7'($random(seed))});
		for (int m = 0; m < 8; m++) begin
			r = 8'($random(seed));
			wr(`RES_ADDR_CTRL, {r[7:2], m[1:0]});
			res_host_model_i.pins(1'b0, m[2], 1'b1);
			#1 chk_static();
			rd_chk(`RES_ADDR_CTRL, 8'h00);
		end
		wr(`RES_ADDR_CTRL, 8'h81);
		res_host_model_i.pins(1'b0, 1'b0, 1'b0);
		wr(`RES_ADDR_VSET_LO, 8'h00);
		rd_chk(`RES_ADDR_VSET_LO, 8'h00);
		res_host_model_i.pins(1'b0, 1'b0, 1'b1);
		for (int a = 0; a < 3; a++) rd_chk(a[7:0], 8'h00);
		$display("test pin low done");
		// start with soft-start ramp
		res_host_model_i.pins(1'b1, 1'b0, 1'b1);
		wait_for(0, 5, n);
		chk_bit("on", 1'b1, regulator_on);
		chk_bit("rectifier", 1'b0, sync_rect_en);
		wait_for(1, 1000, n);
		// one code step per pacing period from zero, plus the cycle into run
		chk_bit("ramp slow", 1'b1, n == `RES_RAMP_STEP_CYC * code + 1);
		chk_code("ref", code[6:0], ref_level);
		rd_chk(`RES_ADDR_MON, 8'h81);
		chk_static();
		$display("test start done");
		// current-limit run, broken once, then tripped
		repeat (15) pulse(1'b1);
		pulse(1'b0);
		repeat (15) pulse(1'b1);
		#1 chk_bit("on", 1'b1, regulator_on);
		pulse(1'b1);
		#1 chk_bit("tristate", 1'b1, switch_tristate);
		chk_bit("on", 1'b0, regulator_on);
		wait_for(0, 1000, n);
		chk_code("off time", 7'(OFF_C), 7'(n));
		chk_code("ref", 7'h00, ref_level);
		$display("test trip done");
		// software run bit, select-driven start, pin shutdown
		wr(`RES_ADDR_VSET_LO, {1'b0, exp_reg[0][6:0]});
		repeat (2) @(posedge ref_clk);
		#1 chk_bit("on", 1'b0, regulator_on);
		chk_static();
		res_host_model_i.pins(1'b1, 1'b1, 1'b1);
		wait_for(0, 5, n);
		chk_bit("on", 1'b1, regulator_on);
		chk_static();
		res_host_model_i.pins(1'b0, 1'b1, 1'b1);
		repeat (3) @(posedge ref_clk);
		#1 chk_bit("on", 1'b0, regulator_on);
		chk_static();
		for (int a = 0; a < 3; a++) rd_chk(a[7:0], 8'h00);
		$display("test software enable done");
		// power-on reset again with the pin already high: defaults return,
		// and the run bits reset high let the regulator start by itself
		res_host_model_i.pins(1'b1, 1'b1, 1'b1);
		resetn <= 1'b0;
		exp_reg[0] = `RES_VSET_RST;
		exp_reg[1] = `RES_VSET_RST;
		exp_reg[2] = `RES_CTRL_RST;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		#1 chk_bit("on", 1'b0, regulator_on);
		wait_for(0, 5, n);
		chk_bit("on", 1'b1, regulator_on);
		chk_code("start delay", 7'h01, 7'(n));
		for (int a = 0; a < 3; a++) rd_chk(a[7:0], 8'h00);
		rd_chk(`RES_ADDR_MON, 8'h82);
		chk_static();
		$display("test reset again done");
		report_and_stop();
	end
endmodule
`default_nettype wire
